// file: hw/sfe_pkg.sv
// constants and types of the serial flash erase host
package sfe_pkg;
  // clock rate in MHz, link timing in ns
  localparam int CLK_MHZ        = 250;   // system clock rate
  localparam int HALF_SCLK_NS   = 24;    // half period of the serial clock
  localparam int CS_GAP_NS      = 50;    // least deselect time between frames
  localparam int SLEEP_ENTRY_NS = 3000;  // sleep_entry_delay, plain default
  localparam int RELEASE_NS     = 30000; // release delay after wake, plain default

  // ns to cycles, rounded up, at least one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // command opcodes
  localparam logic [7:0] OP_UNLOCK    = 8'h06; // write_unlock_cmd
  localparam logic [7:0] OP_SECTOR    = 8'h20; // sector_wipe_cmd
  localparam logic [7:0] OP_SECTOR_W  = 8'h21; // sector_wipe_wide_cmd
  localparam logic [7:0] OP_HALF      = 8'h52; // half_block_wipe_cmd
  localparam logic [7:0] OP_HALF_W    = 8'h5c; // half_block_wipe_wide_cmd
  localparam logic [7:0] OP_FULL      = 8'hd8; // full_block_wipe_cmd
  localparam logic [7:0] OP_FULL_W    = 8'hdc; // full_block_wipe_wide_cmd
  localparam logic [7:0] OP_CHIP      = 8'h60; // whole array wipe
  localparam logic [7:0] OP_CHIP_ALT  = 8'hc7; // whole array wipe, second code
  localparam logic [7:0] OP_SLEEP     = 8'hb9; // deep_sleep_cmd
  localparam logic [7:0] OP_WAKE      = 8'hab; // wake_and_id_cmd
  localparam logic [7:0] OP_UID       = 8'h4b; // unique identifier read
  localparam logic [7:0] OP_WIDE_ON   = 8'hb7; // wide_address_enter_cmd
  localparam logic [7:0] OP_WIDE_OFF  = 8'he9; // leave wide addressing
  localparam logic [7:0] OP_STATUS    = 8'h05; // status byte read

  // frame geometry
  localparam int BYTE_BITS    = 8;
  localparam int ADDR_BYTES_N = 3;   // narrow address bytes
  localparam int ADDR_BYTES_W = 4;   // wide address bytes
  localparam int DUMMY_N      = 4;   // identifier dummy bytes, narrow mode
  localparam int DUMMY_W      = 5;   // identifier dummy bytes, wide mode
  localparam int UID_BITS     = 128;
  localparam int TX_W         = 48;  // opcode plus up to five bytes
  localparam int SR_WIP_BIT   = 0;   // cycle_running_flag in the status byte

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_UID0 = 8'h0c;
  localparam logic [7:0] REG_UID1 = 8'h10;
  localparam logic [7:0] REG_UID2 = 8'h14;
  localparam logic [7:0] REG_UID3 = 8'h18;

  // field positions
  localparam int CTRL_W       = 6;   // kind, wide opcode, alternate opcode
  localparam int CTRL_GO_BIT  = 8;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_WIDE    = 2;
  localparam int STAT_ASLEEP  = 3;
  localparam int STAT_REFUSED = 4;
  localparam int STAT_SR_LSB  = 8;

  // operation kinds held in the control register
  typedef enum logic [3:0] {
    K_SECTOR = 4'h0, K_HALF = 4'h1, K_FULL = 4'h2, K_CHIP = 4'h3, K_SLEEP = 4'h4,
    K_WAKE = 4'h5, K_UID = 4'h6, K_WIDE_ON = 4'h7, K_WIDE_OFF = 4'h8, K_STATUS = 4'h9
  } sfe_kind_e;

  // control register layout
  typedef struct packed {
    logic      alt_op;   // chip wipe uses the second opcode
    logic      wide_op;  // sector, half or full block erase uses the always-wide opcode
    sfe_kind_e kind;
  } sfe_ctrl_s;

  // serial pins driven by the host
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } sfe_pins_s;
  localparam sfe_pins_s PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};

  // sequencer and link states
  typedef enum logic [4:0] {
    SQ_IDLE = 5'b00001, SQ_UNLOCK = 5'b00010, SQ_MAIN = 5'b00100,
    SQ_POLL = 5'b01000, SQ_WAIT = 5'b10000
  } sfe_seq_e;
  typedef enum logic [2:0] {
    LN_IDLE = 3'b001, LN_LOW = 3'b010, LN_HIGH = 3'b100
  } sfe_ln_e;
endpackage

// file: hw/sfe_host.sv
// host controller issuing erase, sleep and identifier commands to a serial flash
`timescale 1ns/1ps
// Functional notes
// - sector wipe opcodes 20H current width, 21H wide
// - host sends write unlock before every erase
// - deselect exactly after last address bit
// - half block opcodes 52H current, 5CH wide
// - full block opcodes D8H current, DCH wide
// - chip wipe 60H or C7H, deselect after opcode
// - deselect right after eighth sleep opcode bit
// - identifier read: 4 dummy bytes, 128 bits out
// - wide mode identifier read uses 5 dummy bytes
// - select held low through whole erase frame
// - keep deselected for release delay after wake
module sfe_host #(
  parameter int HALF_DIV    = sfe_pkg::ns2cyc(sfe_pkg::HALF_SCLK_NS),
  parameter int GAP_CYC     = sfe_pkg::ns2cyc(sfe_pkg::CS_GAP_NS),
  parameter int SLEEP_CYC   = sfe_pkg::ns2cyc(sfe_pkg::SLEEP_ENTRY_NS),
  parameter int RELEASE_CYC = sfe_pkg::ns2cyc(sfe_pkg::RELEASE_NS)
) (
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_SYS_RST,
  // ahb-lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // serial flash pins
  output logic             O_SPI_CS_N,
  output logic             O_SPI_SCLK,
  output logic             O_SPI_MOSI,
  input  wire logic        I_SPI_MISO
);
  import sfe_pkg::*;

  localparam int CW = 16; // width of the wait counter

  // miso synchroniser
  logic                miso_s1_ff;
  logic                miso_s2_ff;
  // bus slave state
  logic                wr_pend_ff;   // write data phase pending
  logic [7:0]          wr_off_ff;    // offset of pending write
  logic [31:0]         hrdata_ff;    // read data for the data phase
  logic                hready_ff;    // always ready, zero wait states
  // software visible registers
  sfe_ctrl_s           ctrl_ff,   nxt_ctrl;
  logic [31:0]         addr_ff,   nxt_addr;
  logic                start_ff,  nxt_start;
  logic                done_ff,   nxt_done;
  logic                refus_ff,  nxt_refus;
  logic                wide_ff,   nxt_wide;    // mirror of wide_address_flag
  logic                asleep_ff, nxt_asleep;
  logic [7:0]          sr_ff,     nxt_sr;      // last status byte read
  logic [UID_BITS-1:0] uid_ff,    nxt_uid;
  // sequencer
  sfe_seq_e            sq_ff,     nxt_sq;
  sfe_seq_e            after_ff,  nxt_after;   // state after the wait
  logic [CW-1:0]       wait_ff,   nxt_wait;
  // link engine
  sfe_ln_e             ln_ff,     nxt_ln;
  sfe_pins_s           pins_ff,   nxt_pins;
  logic [7:0]          div_ff,    nxt_div;
  logic [7:0]          left_ff,   nxt_left;    // bits left in the frame
  logic [7:0]          rxn_ff,    nxt_rxn;     // trailing bits that are read
  logic [TX_W-1:0]     tx_ff,     nxt_tx;
  logic [UID_BITS-1:0] rx_ff,     nxt_rx;
  // frame load request
  logic                ld;
  logic [TX_W-1:0]     ld_tx;
  logic [7:0]          ld_bits;
  logic [7:0]          ld_rx;
  logic [31:0]         rd_mux;

  // opcode for an operation kind
  function automatic logic [7:0] op_of(input sfe_ctrl_s c);
    case (c.kind)
      K_SECTOR:   op_of = c.wide_op ? OP_SECTOR_W : OP_SECTOR;
      K_HALF:     op_of = c.wide_op ? OP_HALF_W : OP_HALF;
      K_FULL:     op_of = c.wide_op ? OP_FULL_W : OP_FULL;
      K_CHIP:     op_of = c.alt_op ? OP_CHIP_ALT : OP_CHIP;
      K_SLEEP:    op_of = OP_SLEEP;
      K_WAKE:     op_of = OP_WAKE;
      K_UID:      op_of = OP_UID;
      K_WIDE_ON:  op_of = OP_WIDE_ON;
      K_WIDE_OFF: op_of = OP_WIDE_OFF;
      default:    op_of = OP_STATUS;
    endcase
  endfunction

  // bus decode
  wire        addr_ph  = I_HSEL & I_HREADY & I_HTRANS[1];
  wire [7:0]  req_off  = I_HADDR[7:0];
  wire        wr_ctrl  = wr_pend_ff & (wr_off_ff == REG_CTRL);
  wire        wr_addr  = wr_pend_ff & (wr_off_ff == REG_ADDR);
  wire        idle     = (sq_ff == SQ_IDLE) & ~start_ff;
  wire        go       = wr_ctrl & I_HWDATA[CTRL_GO_BIT] & idle;
  wire        busy     = ~idle;
  wire [31:0] stat_w   = {16'h0000, sr_ff, 3'b000, refus_ff, asleep_ff, wide_ff,
                          done_ff, busy};

  // operation decode
  wire        has_addr = (ctrl_ff.kind == K_SECTOR) | (ctrl_ff.kind == K_HALF)
                       | (ctrl_ff.kind == K_FULL);
  wire        is_erase = has_addr | (ctrl_ff.kind == K_CHIP);
  wire        is_uid   = ctrl_ff.kind == K_UID;
  wire        is_stat  = ctrl_ff.kind == K_STATUS;
  wire        addr_w   = wide_ff | ctrl_ff.wide_op;
  wire        refuse   = (ctrl_ff.kind > K_STATUS)
                       | (asleep_ff & (ctrl_ff.kind != K_WAKE));
  wire [7:0]  op       = op_of(ctrl_ff);

  // main frame layout
  wire [TX_W-1:0] main_tx = !has_addr ? {op, 40'h0000000000}
                          : addr_w ? {op, addr_ff, 8'h00}
                          : {op, addr_ff[23:0], 16'h0000};
  wire [7:0]  a_bytes  = 8'(addr_w ? ADDR_BYTES_W : ADDR_BYTES_N);
  wire [7:0]  d_bytes  = 8'(wide_ff ? DUMMY_W : DUMMY_N);
  wire [7:0]  main_n   = 8'(has_addr ? BYTE_BITS * (1 + a_bytes)
                       : is_uid ? BYTE_BITS * (1 + d_bytes) + UID_BITS
                       : is_stat ? 2 * BYTE_BITS : BYTE_BITS);
  wire [7:0]  main_r   = 8'(is_uid ? UID_BITS : is_stat ? BYTE_BITS : 0);

  // link timing points
  wire        half_end = div_ff == 8'h00;
  wire        fr_end   = (ln_ff == LN_HIGH) & half_end & (left_ff == 8'h01);
  wire [UID_BITS-1:0] rx_fin = {rx_ff[UID_BITS-2:0], miso_s2_ff};

  // register read selection
  always_comb
  begin
    case (req_off)
      REG_CTRL: rd_mux = {{(32-CTRL_W){1'b0}}, ctrl_ff};
      REG_ADDR: rd_mux = addr_ff;
      REG_STAT: rd_mux = stat_w;
      REG_UID0: rd_mux = uid_ff[31:0];
      REG_UID1: rd_mux = uid_ff[63:32];
      REG_UID2: rd_mux = uid_ff[95:64];
      REG_UID3: rd_mux = uid_ff[127:96];
      default:  rd_mux = 32'h00000000; // unmapped reads zero
    endcase
  end

  // sequencer
  always_comb
  begin
    nxt_ctrl   = wr_ctrl & idle ? sfe_ctrl_s'(I_HWDATA[CTRL_W-1:0]) : ctrl_ff;
    nxt_addr   = wr_addr & idle ? I_HWDATA : addr_ff;
    nxt_start  = go;
    nxt_done   = go ? 1'b0 : done_ff;
    nxt_refus  = go ? 1'b0 : refus_ff;
    nxt_wide   = wide_ff;
    nxt_asleep = asleep_ff;
    nxt_sr     = sr_ff;
    nxt_uid    = uid_ff;
    nxt_sq     = sq_ff;
    nxt_after  = after_ff;
    nxt_wait   = wait_ff;
    ld         = 1'b0;
    ld_tx      = main_tx;
    ld_bits    = 8'(main_n);
    ld_rx      = 8'(main_r);
    case (sq_ff)
      SQ_IDLE:
      begin
        if (start_ff & refuse)
        begin
          // refused: done at once
          nxt_done  = 1'b1;
          nxt_refus = 1'b1;
        end
        else if (start_ff & is_erase)
        begin
          // unlock leads an erase
          ld      = 1'b1;
          ld_tx   = {OP_UNLOCK, 40'h0000000000};
          ld_bits = 8'(BYTE_BITS);
          ld_rx   = 8'h00;
          nxt_sq  = SQ_UNLOCK;
        end
        else if (start_ff)
        begin
          ld     = 1'b1;
          nxt_sq = SQ_MAIN;
        end
      end
      SQ_UNLOCK:
      begin
        if (fr_end)
        begin
          nxt_wait  = CW'(GAP_CYC);
          nxt_after = SQ_MAIN;
          nxt_sq    = SQ_WAIT;
        end
      end
      SQ_MAIN:
      begin
        if (fr_end)
        begin
          // frame effects
          case (ctrl_ff.kind)
            K_UID:      nxt_uid    = rx_fin;
            K_STATUS:   nxt_sr     = rx_fin[7:0];
            K_WIDE_ON:  nxt_wide   = 1'b1;
            K_WIDE_OFF: nxt_wide   = 1'b0;
            K_SLEEP:    nxt_asleep = 1'b1;
            K_WAKE:     nxt_asleep = 1'b0;
            default:    nxt_asleep = asleep_ff;
          endcase
          nxt_sq    = SQ_WAIT;
          nxt_after = is_erase ? SQ_POLL : SQ_IDLE;
          nxt_wait  = (ctrl_ff.kind == K_SLEEP) ? CW'(SLEEP_CYC)
                    : (ctrl_ff.kind == K_WAKE) ? CW'(RELEASE_CYC)
                    : CW'(GAP_CYC);
        end
      end
      SQ_POLL:
      begin
        if (fr_end)
        begin
          // poll while busy
          nxt_sr    = rx_fin[7:0];
          nxt_after = rx_fin[SR_WIP_BIT] ? SQ_POLL : SQ_IDLE;
          nxt_wait  = CW'(GAP_CYC);
          nxt_sq    = SQ_WAIT;
        end
      end
      SQ_WAIT:
      begin
        if (wait_ff != '0)
          nxt_wait = wait_ff - CW'(1);
        else if (after_ff == SQ_MAIN)
        begin
          ld     = 1'b1;
          nxt_sq = SQ_MAIN;
        end
        else if (after_ff == SQ_POLL)
        begin
          ld      = 1'b1;
          ld_tx   = {OP_STATUS, 40'h0000000000};
          ld_bits = 8'(2 * BYTE_BITS);
          ld_rx   = 8'(BYTE_BITS);
          nxt_sq  = SQ_POLL;
        end
        else
        begin
          nxt_done = 1'b1;
          nxt_sq   = SQ_IDLE;
        end
      end
      default: nxt_sq = SQ_IDLE;
    endcase
  end

  // link engine, mode 0, msb first
  always_comb
  begin
    nxt_ln   = ln_ff;
    nxt_pins = pins_ff;
    nxt_div  = half_end ? 8'(HALF_DIV - 1) : div_ff - 8'h01;
    nxt_left = left_ff;
    nxt_rxn  = rxn_ff;
    nxt_tx   = tx_ff;
    nxt_rx   = rx_ff;
    case (ln_ff)
      LN_IDLE:
      begin
        if (ld)
        begin
          // select, first bit out
          nxt_pins = '{cs_n: 1'b0, sclk: 1'b0, mosi: ld_tx[TX_W-1]};
          nxt_tx   = ld_tx;
          nxt_left = ld_bits;
          nxt_rxn  = ld_rx;
          nxt_div  = 8'(HALF_DIV - 1);
          nxt_ln   = LN_LOW;
        end
      end
      LN_LOW:
      begin
        if (half_end)
        begin
          nxt_pins.sclk = 1'b1;
          nxt_ln        = LN_HIGH;
        end
      end
      LN_HIGH:
      begin
        if (half_end)
        begin
          // read bits sampled before fall
          if (left_ff <= rxn_ff)
            nxt_rx = rx_fin;
          nxt_left = left_ff - 8'h01;
          nxt_tx   = {tx_ff[TX_W-2:0], 1'b0};
          if (left_ff == 8'h01)
          begin
            // deselect after last bit
            nxt_pins = PINS_IDLE;
            nxt_ln   = LN_IDLE;
          end
          else
          begin
            nxt_pins.sclk = 1'b0;
            nxt_pins.mosi = tx_ff[TX_W-2];
            nxt_ln        = LN_LOW;
          end
        end
      end
      default: nxt_ln = LN_IDLE;
    endcase
  end

  // bus slave registers
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      wr_pend_ff <= 1'b0;
      wr_off_ff  <= 8'h00;
      hrdata_ff  <= 32'h00000000;
      hready_ff  <= 1'b1;
    end
    else
    begin
      wr_pend_ff <= addr_ph & I_HWRITE;
      wr_off_ff  <= req_off;
      hrdata_ff  <= (addr_ph & ~I_HWRITE) ? rd_mux : hrdata_ff;
      hready_ff  <= 1'b1;
    end
  end

  // data line synchroniser
  always_ff @(posedge I_CLOCK)
  begin
    miso_s1_ff <= I_SPI_MISO;
    miso_s2_ff <= miso_s1_ff;
  end

  // sequencer and link registers
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      ctrl_ff   <= '0;
      addr_ff   <= 32'h00000000;
      start_ff  <= 1'b0;
      done_ff   <= 1'b0;
      refus_ff  <= 1'b0;
      wide_ff   <= 1'b0;
      asleep_ff <= 1'b0;
      sr_ff     <= 8'h00;
      uid_ff    <= '0;
      sq_ff     <= SQ_IDLE;
      after_ff  <= SQ_IDLE;
      wait_ff   <= '0;
      ln_ff     <= LN_IDLE;
      pins_ff   <= PINS_IDLE;
      div_ff    <= 8'h00;
      left_ff   <= 8'h00;
      rxn_ff    <= 8'h00;
      tx_ff     <= '0;
      rx_ff     <= '0;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      addr_ff   <= nxt_addr;
      start_ff  <= nxt_start;
      done_ff   <= nxt_done;
      refus_ff  <= nxt_refus;
      wide_ff   <= nxt_wide;
      asleep_ff <= nxt_asleep;
      sr_ff     <= nxt_sr;
      uid_ff    <= nxt_uid;
      sq_ff     <= nxt_sq;
      after_ff  <= nxt_after;
      wait_ff   <= nxt_wait;
      ln_ff     <= nxt_ln;
      pins_ff   <= nxt_pins;
      div_ff    <= nxt_div;
      left_ff   <= nxt_left;
      rxn_ff    <= nxt_rxn;
      tx_ff     <= nxt_tx;
      rx_ff     <= nxt_rx;
    end
  end

  // outputs straight from flip-flops, error response tied low
  assign O_HRDATA    = hrdata_ff;
  assign O_HREADYOUT = hready_ff;
  assign O_HRESP     = 1'b0;
  assign O_SPI_CS_N  = pins_ff.cs_n;
  assign O_SPI_SCLK  = pins_ff.sclk;
  assign O_SPI_MOSI  = pins_ff.mosi;
endmodule

// file: verif/sfe_host_asserts.sv
// pin-level checker for the serial flash erase host
`timescale 1ns/1ps
module sfe_host_asserts
  import sfe_pkg::*;
#(
  parameter int HALF_DIV    = 6,
  parameter int SLEEP_CYC   = 750,
  parameter int RELEASE_CYC = 7500
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // serial pins
  input wire logic O_SPI_CS_N,
  input wire logic O_SPI_SCLK,
  input wire logic O_SPI_MOSI
);
  logic        sclk_q_ff;  // clock one sample ago
  logic        cs_q_ff;    // select one sample ago
  logic [8:0]  bits_ff;    // clock rises in this frame
  logic [7:0]  op_ff;      // first byte of the frame
  logic [7:0]  last_ff;    // previous opcode
  logic [15:0] hi_ff;      // samples with clock high
  logic [15:0] gap_ff;     // deselected samples
  logic        ads_ff;     // wide mode seen
  // frame decode
  wire rise_w = O_SPI_SCLK & ~sclk_q_ff;
  wire end_w  = O_SPI_CS_N & ~cs_q_ff;
  wire wide_w = (op_ff == OP_SECTOR_W) | (op_ff == OP_HALF_W) | (op_ff == OP_FULL_W);
  wire wipe_w = wide_w | (op_ff == OP_SECTOR) | (op_ff == OP_HALF) | (op_ff == OP_FULL);
  wire chip_w = (op_ff == OP_CHIP) | (op_ff == OP_CHIP_ALT);
  wire one_w  = chip_w | (op_ff == OP_SLEEP) | (op_ff == OP_WAKE) | (op_ff == OP_UNLOCK)
              | (op_ff == OP_WIDE_ON) | (op_ff == OP_WIDE_OFF);
  // frame tracking on the system clock
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      sclk_q_ff <= 1'b0;
      cs_q_ff   <= 1'b1;
      bits_ff   <= 9'h0;
      op_ff     <= 8'h0;
      last_ff   <= 8'h0;
      hi_ff     <= 16'h0;
      gap_ff    <= 16'hffff;
      ads_ff    <= 1'b0;
    end
    else
    begin
      sclk_q_ff <= O_SPI_SCLK;
      cs_q_ff   <= O_SPI_CS_N;
      bits_ff   <= O_SPI_CS_N ? 9'h0 : bits_ff + {8'h0, rise_w};
      hi_ff     <= O_SPI_SCLK ? hi_ff + 16'h1 : 16'h0;
      gap_ff    <= O_SPI_CS_N ? gap_ff + {15'h0, ~&gap_ff} : 16'h0;
      if (rise_w && bits_ff < 9'h8)
        op_ff <= {op_ff[6:0], O_SPI_MOSI};
      if (end_w)
        last_ff <= op_ff;
      if (end_w && op_ff == OP_WIDE_ON)
        ads_ff <= 1'b1;
      if (end_w && op_ff == OP_WIDE_OFF)
        ads_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);
  AST_SCLK_IDLE: assert property (O_SPI_CS_N |-> !O_SPI_SCLK)
    else $error("clock while idle");
  AST_MOSI_HOLD: assert property (O_SPI_SCLK |-> $stable(O_SPI_MOSI))
    else $error("data moved");
  AST_HALF_HIGH: assert property ($fell(O_SPI_SCLK) |-> hi_ff == HALF_DIV)
    else $error("high half length");
  AST_END_ON_BYTE: assert property ($rose(O_SPI_CS_N) |-> $past(O_SPI_SCLK) && bits_ff[2:0] == 3'h0)
    else $error("end off byte");
  AST_ERASE_LEN: assert property ($rose(O_SPI_CS_N) && wipe_w |-> bits_ff == ((wide_w || ads_ff) ? 40 : 32))
    else $error("erase length");
  AST_SHORT_LEN: assert property ($rose(O_SPI_CS_N) && one_w |-> bits_ff == 9'h8)
    else $error("opcode length");
  AST_UID_LEN: assert property ($rose(O_SPI_CS_N) && op_ff == OP_UID |-> bits_ff == (ads_ff ? 176 : 168))
    else $error("id length");
  AST_UNLOCK_FIRST: assert property ($rose(O_SPI_CS_N) && (wipe_w || chip_w) |-> last_ff == OP_UNLOCK)
    else $error("no unlock");
  AST_WAKE_HOLD: assert property ($fell(O_SPI_CS_N) && last_ff == OP_WAKE |-> gap_ff >= RELEASE_CYC)
    else $error("wake gap");
  AST_SLEEP_HOLD: assert property ($fell(O_SPI_CS_N) && last_ff == OP_SLEEP |-> gap_ff >= SLEEP_CYC)
    else $error("sleep gap");
  // main scenarios reached
  cover property ($rose(O_SPI_CS_N) && wipe_w && ads_ff);
  cover property ($rose(O_SPI_CS_N) && op_ff == OP_UID);
  cover property ($fell(O_SPI_CS_N) && last_ff == OP_WAKE);
endmodule
bind sfe_host sfe_host_asserts #(.HALF_DIV(HALF_DIV), .SLEEP_CYC(SLEEP_CYC),
  .RELEASE_CYC(RELEASE_CYC)) u_chk (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
  .O_SPI_CS_N(O_SPI_CS_N), .O_SPI_SCLK(O_SPI_SCLK), .O_SPI_MOSI(O_SPI_MOSI));

// file: verif/sfe_flash_model.sv
// serial flash model for erase, sleep and identifier frames
`timescale 1ns/1ps
module sfe_flash_model
  import sfe_pkg::*;
#(
  parameter int           WIPE_NS  = 2000, // erase cycle length, plain default
  parameter int           SLEEP_NS = 40,   // sleep entry delay, plain default
  parameter logic [127:0] UID      = 128'h0  // identifier, set by the bench
) (
  // serial pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // protection control and observation
  input  wire logic        i_prot,
  output logic      [31:0] o_wipes,
  output logic      [7:0]  o_op,
  output logic      [31:0] o_addr,
  output logic             o_asleep,
  output logic             o_ads
);
  logic [7:0]   op;    // opcode of the frame
  logic [31:0]  sh;    // last 32 bits in
  int           nb;    // bits in this frame
  logic         write_unlock_latch;   // write_unlock_latch
  logic         cycle_running_flag;   // cycle_running_flag
  logic         wide;  // four address bytes
  logic [127:0] out_q; // bits left to send
  // power-up state: awake, narrow, idle
  initial
  begin
    {o_miso, write_unlock_latch, cycle_running_flag, o_ads, op, nb, out_q} = '0;
    o_asleep = 1'b0;
    o_wipes = 32'h0;
    o_op = 8'h0;
    o_addr = 32'h0;
  end
  // start an erase if unlocked and unprotected
  task automatic wipe(input logic [31:0] a);
    if (write_unlock_latch && !cycle_running_flag && !i_prot)
    begin
      cycle_running_flag = 1'b1;
      o_op = op;
      o_addr = a;
      o_wipes = o_wipes + 32'h1;
      fork
        begin
          #(WIPE_NS);
          write_unlock_latch = 1'b0;
          cycle_running_flag = 1'b0;
        end
      join_none
    end
  endtask
  // frame start clears the count
  always @(negedge i_cs_n)
    nb = 0;
  // shift in on the rising clock, msb first
  always @(posedge i_sclk)
  begin
    if (!i_cs_n)
    begin
      sh = {sh[30:0], i_mosi};
      if (nb < 8)
        op = {op[6:0], i_mosi};
      nb++;
    end
  end
  // shift out on the falling clock
  always @(negedge i_sclk)
  begin
    if (!i_cs_n && o_asleep)
      o_miso = ~o_miso;
    else if (!i_cs_n)
    begin
      if (op == OP_STATUS && nb == 8)
        out_q = {6'h0, write_unlock_latch, cycle_running_flag, 120'h0};
      if (op == OP_UID && nb == (o_ads ? 48 : 40))
        out_q = UID;
      o_miso = out_q[127];
      out_q = out_q << 1;
    end
  end
  // frame end: decode and act
  always @(posedge i_cs_n)
  begin
    o_miso = ~o_miso;
    wide = o_ads || (op inside {OP_SECTOR_W, OP_HALF_W, OP_FULL_W});
    if (o_asleep)
    begin
      if (op == OP_WAKE && nb == 8)
        o_asleep = 1'b0;
    end
    else if (nb == 8)
      case (op)
        OP_UNLOCK:            write_unlock_latch = 1'b1;
        OP_WIDE_ON:           o_ads = 1'b1;
        OP_WIDE_OFF:          o_ads = 1'b0;
        OP_CHIP, OP_CHIP_ALT: wipe(32'h0);
        OP_SLEEP:             if (!cycle_running_flag) fork #(SLEEP_NS) o_asleep = 1'b1; join_none
        default:              ;
      endcase
    else if ((op inside {OP_SECTOR, OP_HALF, OP_FULL}) || wide)
      if (nb == (wide ? 40 : 32))
        wipe(wide ? sh : {8'h0, sh[23:0]});
  end
endmodule

// file: verif/sfe_host_bench.sv
// self-checking bench for the serial flash erase host
`timescale 1ns/1ps
module sfe_host_bench;
  import sfe_pkg::*;
  localparam logic [127:0] UID_VAL = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210; // arbitrary
  logic        clk, rst, hsel, hwrite, hready, hresp, cs_n, sclk, mosi, miso, prot, asleep, wide_address_flag;
  logic [31:0] haddr, hwdata, hrdata, wipes, addr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  op;
  int          error_cnt, checks, cycles;
  // design and flash
  sfe_host #(.SLEEP_CYC(20), .RELEASE_CYC(20)) dut (.I_CLOCK(clk), .I_SYS_RST(rst),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .O_SPI_CS_N(cs_n), .O_SPI_SCLK(sclk), .O_SPI_MOSI(mosi), .I_SPI_MISO(miso));
  sfe_flash_model #(.UID(UID_VAL)) u_flash (.i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
    .o_miso(miso), .i_prot(prot), .o_wipes(wipes), .o_op(op), .o_addr(addr),
    .o_asleep(asleep), .o_ads(wide_address_flag));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      stop_test();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // start and poll until done
  task automatic run(input logic [5:0] c, input logic [31:0] a, output logic [31:0] st);
    bus(1'b1, REG_ADDR, a, st);
    bus(1'b1, REG_CTRL, {23'h0, 1'b1, 2'h0, c}, st);
    bus(1'b0, REG_STAT, 32'h0, st);
    do bus(1'b0, REG_STAT, 32'h0, st); while (st[STAT_DONE] !== 1'b1);
  endtask
  // identifier read and word check
  task automatic uid_read(input logic [31:0] exp_st);
    logic [31:0] rd;
    run(6'h06, 32'h0, rd);
    chk32(rd, exp_st);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, REG_UID0 + 8'(4 * k), 32'h0, rd);
      chk32(rd, UID_VAL[32 * k +: 32]);
    end
  endtask
  task automatic t_reset;
    logic [31:0] rd;
    chk32({31'h0, asleep}, 32'h0);
    bus(1'b0, REG_STAT, 32'h0, rd);
    chk32(rd, 32'h0);
    bus(1'b1, 8'h40, 32'hffff_ffff, rd);
    bus(1'b0, 8'h40, 32'h0, rd);
    chk32({rd[31:1], hresp}, 32'h0);
  endtask
  // all eight erase opcodes, consecutive addresses from 5a0ff001
  task automatic t_erase;
    logic [5:0]  ctl [6] = '{6'h00, 6'h01, 6'h02, 6'h10, 6'h11, 6'h12};
    logic [7:0]  opc [6] = '{OP_SECTOR, OP_HALF, OP_FULL, OP_SECTOR_W, OP_HALF_W, OP_FULL_W};
    logic [31:0] a, st, n;
    for (int i = 0; i < 6; i++)
    begin
      n = wipes;
      a = 32'h5a0f_f001 + 32'(i);
      run(ctl[i], a, st);
      chk32(st, 32'h2);
      chk32(wipes, n + 32'h1);
      chk32({24'h0, op}, {24'h0, opc[i]});
      chk32(addr, ctl[i][4] ? a : {8'h0, a[23:0]});
    end
    for (int i = 0; i < 2; i++)
    begin
      run({i[0], 1'b0, 4'h3}, 32'h0, st);
      chk32({24'h0, op}, {24'h0, i[0] ? OP_CHIP_ALT : OP_CHIP});
      chk32(wipes, n + 32'(2 + i));
    end
  endtask
  task automatic t_wide;
    logic [31:0] st;
    run(6'h07, 32'h0, st);
    chk32(st, 32'h6);
    run(6'h00, 32'h1234_5678, st);
    chk32(addr, 32'h1234_5678);
    uid_read(32'h6);
    run(6'h08, 32'h0, st);
    chk32({31'h0, wide_address_flag}, 32'h0);
    uid_read(32'h2);
    run(6'h09, 32'h0, st);
    chk32(st, 32'h2);
  endtask
  // protected array: nothing may be wiped
  task automatic t_protect;
    logic [31:0] st, n;
    prot <= 1'b1;
    n = wipes;
    for (int k = 0; k < 4; k++)
    begin
      run({2'h0, 4'(k)}, 32'h0001_0000, st);
      chk32(st, 32'h202);
    end
    chk32(wipes, n);
    prot <= 1'b0;
  endtask
  task automatic t_sleep;
    logic [31:0] st, n;
    n = wipes;
    run(6'h04, 32'h0, st);
    chk32({st[31:1], asleep}, 32'h20b);
    run(6'h00, 32'h0, st);
    chk32(st, 32'h21a);
    run(6'h05, 32'h0, st);
    chk32({st[31:1], asleep}, 32'h202);
    chk32(wipes, n);
    run(6'h0a, 32'h0, st);
    chk32(st, 32'h212);
  endtask
  initial
  begin
    {rst, hsel, hwrite, prot, haddr, hwdata, htrans, error_cnt, checks, cycles} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_erase();
    t_wide();
    t_protect();
    t_sleep();
    stop_test();
  end
endmodule
